/* File: logic/adif_top.sv */
// Purpose: Sticky and live event flags with two interrupt pulse lines.
// Assumes: Detector levels are asynchronous; overflow flags share the clock.
// Notes:   Registers are reached through a plain byte-wide register port.
`timescale 1ns/1ps
module adif_top
  import adif_pkg::*;
#(
  parameter int PULSE_CYCLES  = PULSE_CYC,
  parameter int PERIOD_CYCLES = PERIOD_CYC
)
(
  // Clock and reset.
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  // Register port.
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // Detector levels, asynchronous.
  input  wire logic       short_left_i,
  input  wire logic       short_right_i,
  input  wire logic       button_i,
  input  wire logic       headset_in_i,
  input  wire logic       power_left_i,
  input  wire logic       power_right_i,
  // Overflow flags from the overflow flag register.
  input  wire logic [2:0] ovf_flags_i,
  // Interrupt lines.
  output logic            irq_line_a_o,
  output logic            irq_line_b_o
);

  // Gathers the enabled events of one line into a single trigger.
  function automatic logic line_trig(input logic [7:0] ctrl,
                                     input logic [7:0] ev,
                                     input logic       ovf);
    logic t;
    t = (ctrl[E_HEADSET] & ev[B_HEADSET])
      | (ctrl[E_BUTTON] & ev[B_BUTTON])
      | (ctrl[E_PWR] & (ev[B_PWR_L] | ev[B_PWR_R]))
      | (ctrl[E_SHORT] & (ev[B_SHORT_L] | ev[B_SHORT_R]))
      | (ctrl[E_OVF] & ovf);
    return t;
  endfunction

  logic [NUM_DET-1:0] det_raw;
  logic [NUM_DET-1:0] det_s;
  logic [NUM_DET-1:0] det_prev_q;
  logic [2:0]         ovf_prev_q;
  logic [7:0]         sticky_q;
  logic [7:0]         sticky_d;
  logic [7:0]         ctrl_a_q;
  logic [7:0]         ctrl_b_q;
  logic [7:0]         rsvd_2d_q;
  logic [7:0]         rsvd_2f_q;
  logic [7:0]         rdata_q;

  adif_line_if line_a ();
  adif_line_if line_b ();

  // Detector order matches the flag bit order from bit 7 down to bit 2.
  assign det_raw = {short_left_i, short_right_i, button_i,
                    headset_in_i, power_left_i, power_right_i};

  adif_sync #(
    .W (NUM_DET)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .d_i       (det_raw),
    .q_o       (det_s)
  );

  // Levels become events on their rising edge, except the headset, which
  // reports both insertion and removal.
  wire [NUM_DET-1:0] det_rise = det_s & ~det_prev_q;
  wire [NUM_DET-1:0] det_chg  = det_s ^ det_prev_q;
  wire [7:0] ev_rise = {det_rise, RSVD_LO};
  wire [7:0] ev_chg  = {det_chg, RSVD_LO};

  wire ev_short_l = ev_rise[B_SHORT_L];
  wire ev_short_r = ev_rise[B_SHORT_R];
  wire ev_button  = ev_rise[B_BUTTON];
  wire ev_headset = ev_chg[B_HEADSET];
  wire ev_pwr_l   = ev_rise[B_PWR_L];
  wire ev_pwr_r   = ev_rise[B_PWR_R];

  wire [7:0] ev8 = {ev_short_l, ev_short_r, ev_button, ev_headset,
                    ev_pwr_l, ev_pwr_r, RSVD_LO};

  // A new overflow is any flag rising; the flags fall when software reads
  // them, so a later overflow rises again.
  wire ovf_ev = |(ovf_flags_i & ~ovf_prev_q);

  // Register decode.
  wire sel_sticky = (reg_addr_i == ADDR_STICKY);
  wire sel_rsvd_a = (reg_addr_i == ADDR_RSVD_2D);
  wire sel_status = (reg_addr_i == ADDR_STATUS);
  wire sel_rsvd_b = (reg_addr_i == ADDR_RSVD_2F);
  wire sel_line_a = (reg_addr_i == ADDR_LINE_A);
  wire sel_line_b = (reg_addr_i == ADDR_LINE_B);
  wire rd_sticky  = reg_rd_i & sel_sticky;
  wire [7:0] live = {det_s, RSVD_LO};

  // Set wins over the read clear so no event is lost.
  assign sticky_d = (sticky_q & ~{8{rd_sticky}}) | ev8;

  wire [7:0] rd_mux = sel_sticky ? sticky_q :
                      sel_rsvd_a ? rsvd_2d_q :
                      sel_status ? live :
                      sel_rsvd_b ? rsvd_2f_q :
                      sel_line_a ? ctrl_a_q :
                      sel_line_b ? ctrl_b_q :
                      RST_ZERO;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      det_prev_q <= '0;
      ovf_prev_q <= '0;
      sticky_q   <= RST_ZERO;
      rdata_q    <= RST_ZERO;
    end
    else
    begin
      det_prev_q <= det_s;
      ovf_prev_q <= ovf_flags_i;
      sticky_q   <= sticky_d;
      if (reg_rd_i)
        rdata_q <= rd_mux;
    end
  end

  // Writable registers; reserved ones simply hold what is written.
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_a_q  <= RST_ZERO;
      ctrl_b_q  <= RST_ZERO;
      rsvd_2d_q <= RST_ZERO;
      rsvd_2f_q <= RST_ZERO;
    end
    else if (reg_wr_i)
    begin
      if (sel_line_a)
        ctrl_a_q <= reg_wdata_i;
      if (sel_line_b)
        ctrl_b_q <= reg_wdata_i;
      if (sel_rsvd_a)
        rsvd_2d_q <= reg_wdata_i;
      if (sel_rsvd_b)
        rsvd_2f_q <= reg_wdata_i;
    end
  end

  assign reg_rdata_o = rdata_q;

  // Line A.
  assign line_a.trig        = line_trig(ctrl_a_q, ev8,
                                        ovf_ev);
  assign line_a.repeat_mode = ctrl_a_q[E_REPEAT];
  assign line_a.stop        = rd_sticky;

  // Line B.
  assign line_b.trig        = line_trig(ctrl_b_q, ev8,
                                        ovf_ev);
  assign line_b.repeat_mode = ctrl_b_q[E_REPEAT];
  assign line_b.stop        = rd_sticky;

  adif_pulse_gen #(
    .HIGH_CYCLES (PULSE_CYCLES),
    .LOW_CYCLES  (PERIOD_CYCLES - PULSE_CYCLES)
  ) u_pulse_a (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .line_if   (line_a.gen)
  );

  adif_pulse_gen #(
    .HIGH_CYCLES (PULSE_CYCLES),
    .LOW_CYCLES  (PERIOD_CYCLES - PULSE_CYCLES)
  ) u_pulse_b (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .line_if   (line_b.gen)
  );

  assign irq_line_a_o = line_a.line;
  assign irq_line_b_o = line_b.line;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  AST_SHORT_SET: assert property
    ((det_rise[NUM_DET-1] |=> sticky_q[B_SHORT_L])
     and (det_rise[NUM_DET-2] |=> sticky_q[B_SHORT_R]))
    else $error("Short event not latched in the sticky flags.");

  AST_READ_CLEAR: assert property
    (rd_sticky && ev8 == RST_ZERO |=> sticky_q == RST_ZERO)
    else $error("Sticky flags not cleared by a read.");

  AST_STICKY_HOLD: assert property
    (!rd_sticky |=> (sticky_q & $past(sticky_q)) == $past(sticky_q))
    else $error("Sticky flag dropped without a read.");

  AST_SET_WINS: assert property
    (rd_sticky && ev_button |=> sticky_q[B_BUTTON])
    else $error("Event lost in the cycle of a read.");

  AST_BUTTON_HEADSET: assert property
    ((ev_button |=> sticky_q[B_BUTTON])
     and ($changed(det_s[NUM_DET-4]) |-> ##1 sticky_q[B_HEADSET]))
    else $error("Button or headset event not latched.");

  AST_POWER_SET: assert property
    ((ev_pwr_l |=> sticky_q[B_PWR_L]) and (ev_pwr_r |=> sticky_q[B_PWR_R]))
    else $error("Power threshold event not latched.");

  AST_STATUS_READ: assert property
    (reg_rd_i && sel_status |=> reg_rdata_o == $past(live))
    else $error("Live status read does not show present state.");

  AST_RSVD_LOW: assert property
    (sticky_q[1:0] == RSVD_LO)
    else $error("Reserved sticky bits are not zero.");

  AST_A_SHORT: assert property
    (ctrl_a_q[E_SHORT] && (ev_short_l || ev_short_r) && !line_a.busy
     |=> irq_line_a_o)
    else $error("Enabled short event did not start line A.");

  AST_A_HEADSET: assert property
    (ctrl_a_q[E_HEADSET] && ev_headset && !line_a.busy |=> irq_line_a_o)
    else $error("Enabled headset event did not start line A.");

  AST_B_OVF: assert property
    (ctrl_b_q[E_OVF] && ovf_ev && !line_b.busy |=> irq_line_b_o)
    else $error("Enabled overflow event did not start line B.");

  AST_B_BUTTON: assert property
    (ctrl_b_q[E_BUTTON] && ev_button && !line_b.busy |=> irq_line_b_o)
    else $error("Enabled button event did not start line B.");

  AST_A_CAUSE: assert property
    ($rose(irq_line_a_o) && !$past(line_a.busy) |-> $past(line_a.trig))
    else $error("Line A rose without an enabled event.");

  AST_B_SINGLE: assert property
    (!$past(ctrl_b_q[E_REPEAT]) && $fell(irq_line_b_o) && !line_b.trig
     |-> !line_b.busy)
    else $error("Line B kept running in single mode.");

  AST_A_BUTTON: assert property
    (ctrl_a_q[E_BUTTON] && ev_button && !line_a.busy |=> irq_line_a_o)
    else $error("Enabled button event did not start line A.");

  AST_A_POWER: assert property
    (ctrl_a_q[E_PWR] && (ev_pwr_l || ev_pwr_r) && !line_a.busy
     |=> irq_line_a_o)
    else $error("Enabled power event did not start line A.");

  AST_A_OVF: assert property
    (ctrl_a_q[E_OVF] && ovf_ev && !line_a.busy |=> irq_line_a_o)
    else $error("Enabled overflow event did not start line A.");

  AST_B_HEADSET: assert property
    (ctrl_b_q[E_HEADSET] && ev_headset && !line_b.busy |=> irq_line_b_o)
    else $error("Enabled headset event did not start line B.");

  AST_B_POWER: assert property
    (ctrl_b_q[E_PWR] && (ev_pwr_l || ev_pwr_r) && !line_b.busy
     |=> irq_line_b_o)
    else $error("Enabled power event did not start line B.");

  AST_B_SHORT: assert property
    (ctrl_b_q[E_SHORT] && (ev_short_l || ev_short_r) && !line_b.busy
     |=> irq_line_b_o)
    else $error("Enabled short event did not start line B.");

  AST_B_CAUSE: assert property
    ($rose(irq_line_b_o) && !$past(line_b.busy) |-> $past(line_b.trig))
    else $error("Line B rose without an enabled event.");

  AST_A_SINGLE: assert property
    (!$past(ctrl_a_q[E_REPEAT]) && $fell(irq_line_a_o) |-> !line_a.busy)
    else $error("Line A kept running in single mode.");

  AST_A_MASKED: assert property
    (!line_a.busy && !ctrl_a_q[E_HEADSET] && !ctrl_a_q[E_BUTTON]
     && !ctrl_a_q[E_PWR] && !ctrl_a_q[E_SHORT] && !ctrl_a_q[E_OVF]
     |=> !irq_line_a_o)
    else $error("Line A rose with all its events masked.");

  AST_B_MASKED: assert property
    (!line_b.busy && !ctrl_b_q[E_HEADSET] && !ctrl_b_q[E_BUTTON]
     && !ctrl_b_q[E_PWR] && !ctrl_b_q[E_SHORT] && !ctrl_b_q[E_OVF]
     |=> !irq_line_b_o)
    else $error("Line B rose with all its events masked.");

  AST_STICKY_READ: assert property
    (rd_sticky |=> reg_rdata_o == $past(sticky_q))
    else $error("Sticky read did not return the flags before clearing.");

  AST_NO_NEW_SET: assert property
    (!rd_sticky && ev8 == RST_ZERO |=> $stable(sticky_q))
    else $error("Sticky flag set without a new event.");

  AST_CTRL_WRITE: assert property
    ((reg_wr_i && sel_line_a |=> ctrl_a_q == $past(reg_wdata_i))
     and (reg_wr_i && sel_line_b |=> ctrl_b_q == $past(reg_wdata_i)))
    else $error("Line control write did not take effect.");

  COV_STICKY_READ: cover property
    (rd_sticky && sticky_q != RST_ZERO);
  COV_A_REPEAT: cover property
    (ctrl_a_q[E_REPEAT] && $fell(irq_line_a_o) ##[1:8] line_a.busy);
  COV_B_SINGLE: cover property
    (!ctrl_b_q[E_REPEAT] && $rose(irq_line_b_o));
  COV_OVF: cover property
    (ovf_ev && ctrl_a_q[E_OVF]);

endmodule

/* File: logic/adif_pkg.sv */
// Purpose: Shared constants and types of the audio converter interrupt flags.
// Assumes: One 25 MHz clock; 8-bit registers at their byte offsets.
// Notes:   Bit positions follow the flag and line control register layouts.
package adif_pkg;

  // Clock and interrupt pulse timing.
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned HZ_PER_MHZ = 1_000_000;
  localparam int unsigned PULSE_US   = 2000;
  localparam int unsigned PERIOD_US  = 4000;
  localparam int unsigned PULSE_CYC  = PULSE_US * (CLK_HZ / HZ_PER_MHZ);
  localparam int unsigned PERIOD_CYC = PERIOD_US * (CLK_HZ / HZ_PER_MHZ);
  localparam int          CNT_W      = 17;

  // Register offsets.
  localparam logic [7:0] ADDR_STICKY    = 8'h2C;
  localparam logic [7:0] ADDR_RSVD_2D   = 8'h2D;
  localparam logic [7:0] ADDR_STATUS    = 8'h2E;
  localparam logic [7:0] ADDR_RSVD_2F   = 8'h2F;
  localparam logic [7:0] ADDR_LINE_A    = 8'h30;
  localparam logic [7:0] ADDR_LINE_B    = 8'h31;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [1:0] RSVD_LO        = 2'h0;

  // Flag bit positions, shared by the sticky and live registers.
  localparam int B_SHORT_L = 7;
  localparam int B_SHORT_R = 6;
  localparam int B_BUTTON  = 5;
  localparam int B_HEADSET = 4;
  localparam int B_PWR_L   = 3;
  localparam int B_PWR_R   = 2;
  localparam int NUM_DET   = 6;

  // Line control bit positions.
  localparam int E_HEADSET = 7;
  localparam int E_BUTTON  = 6;
  localparam int E_PWR     = 5;
  localparam int E_SHORT   = 3;
  localparam int E_OVF     = 2;
  localparam int E_REPEAT  = 0;

  typedef enum logic [2:0]
  {
    PG_IDLE = 3'h1,
    PG_HIGH = 3'h2,
    PG_LOW  = 3'h4
  } adif_pg_state_type;

endpackage

/* File: logic/adif_line_if.sv */
// Purpose: Carries one interrupt line between the flag logic and its pulser.
// Assumes: All signals on ref_clk_i.
// Notes:   trig and stop are one-cycle pulses.
`timescale 1ns/1ps
interface adif_line_if;
  logic trig;
  logic repeat_mode;
  logic stop;
  logic line;
  logic busy;
  modport ctrl (output trig, output repeat_mode, output stop,
                input line, input busy);
  modport gen  (input trig, input repeat_mode, input stop,
                output line, output busy);
endinterface

/* File: logic/adif_sync.sv */
// Purpose: Two-stage synchroniser for asynchronous detector levels.
// Assumes: Inputs are slow levels.
// Notes:   The first stage feeds only the second.
`timescale 1ns/1ps
module adif_sync
  import adif_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset.
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  // Data.
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

/* File: logic/adif_pulse_gen.sv */
// Purpose: Interrupt line pulser, single pulse or repeating pulses.
// Assumes: trig and stop are one-cycle pulses on ref_clk_i.
// Notes:   A stop during a high phase lets that pulse finish first.
`timescale 1ns/1ps
module adif_pulse_gen
  import adif_pkg::*;
#(
  parameter int HIGH_CYCLES = PULSE_CYC,
  parameter int LOW_CYCLES  = PERIOD_CYC - PULSE_CYC
)
(
  // Clock and reset.
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  // Line handshake.
  adif_line_if.gen  line_if
);

  localparam logic [CNT_W-1:0] HI_LAST = CNT_W'(HIGH_CYCLES - 1);
  localparam logic [CNT_W-1:0] LO_LAST = CNT_W'(LOW_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  adif_pg_state_type state_q;
  adif_pg_state_type state_d;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cnt_d;
  logic              stop_q;
  logic              stop_d;
  logic              line_q;

  wire hi_done = (cnt_q == HI_LAST);
  wire lo_done = (cnt_q == LO_LAST);
  wire stop_any = stop_q | line_if.stop;

  // Widths come from counting device clocks against the parameters.
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q + CNT_ONE;
    stop_d  = stop_any;
    case (state_q)
      PG_IDLE:
      begin
        cnt_d  = '0;
        stop_d = 1'b0;
        if (line_if.trig)
          state_d = PG_HIGH;
      end
      PG_HIGH:
        if (hi_done)
        begin
          cnt_d = '0;
          if (line_if.repeat_mode && !stop_any)
            state_d = PG_LOW;
          else
            state_d = PG_IDLE;
        end
      PG_LOW:
        if (stop_any || !line_if.repeat_mode)
        begin
          cnt_d   = '0;
          state_d = PG_IDLE;
        end
        else if (lo_done)
        begin
          cnt_d   = '0;
          state_d = PG_HIGH;
        end
      default:
      begin
        cnt_d   = '0;
        stop_d  = 1'b0;
        state_d = PG_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= PG_IDLE;
      cnt_q   <= '0;
      stop_q  <= 1'b0;
      line_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      stop_q  <= stop_d;
      line_q  <= (state_d == PG_HIGH);
    end
  end

  assign line_if.line = line_q;
  assign line_if.busy = (state_q != PG_IDLE);

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  AST_PG_FIRST: assert property
    ($rose(line_q) |-> cnt_q == '0)
    else $error("Pulse did not start from a cleared count.");
  AST_PG_HOLD: assert property
    (line_q && cnt_q != HI_LAST |=> line_q)
    else $error("Pulse dropped before its full width.");
  AST_PG_END: assert property
    (line_q && hi_done |=> !line_q)
    else $error("Pulse exceeded its width.");
  AST_PG_REPEAT: assert property
    (state_q == PG_LOW && lo_done && !stop_any && line_if.repeat_mode
     |=> line_q)
    else $error("Repeat pulse missing after low phase.");
  AST_PG_STOP: assert property
    (state_q == PG_LOW && line_if.stop
     |=> (state_q == PG_IDLE && !line_q)
         ##1 (!line_q || $past(line_if.trig)))
    else $error("Repeat pulses continued after the flags were read.");

  COV_PG_REPEAT: cover property
    (state_q == PG_LOW ##1 $rose(line_q));

endmodule

/* File: sim/adif_host_model.sv */
// Purpose: Host side of the register port, issuing byte reads and writes.
// Assumes: Strobes change at the falling edge and last one clock cycle.
// Notes:   Idle address and data show the inverse of the last value.
`timescale 1ns/1ps
module adif_host_model
  import adif_pkg::*;
(
  // Clock.
  input  wire logic       ref_clk_i,
  // Register port.
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial
  begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o    = 1'b0;
  end

  // Reserved offsets only ever get zeros from this host.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_o  = a;
    reg_wdata_o = (a == ADDR_RSVD_2D || a == ADDR_RSVD_2F) ? RST_ZERO
                                                           : d;
    reg_wr_o    = 1'b1;
    @(negedge ref_clk_i);
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~a;
    reg_wdata_o = ~reg_wdata_o;
  endtask

  // Data is taken a full cycle after the strobe, where it is settled.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge ref_clk_i);
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
    @(negedge ref_clk_i);
    d = reg_rdata_i;
  endtask
endmodule

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the event flags and interrupt lines.
// Assumes: Short pulse parameters so that repeats fit in a few cycles.
// Notes:   Line windows count rises and high cycles, not exact phases.
`timescale 1ns/1ps
module tb_top;
  import adif_pkg::*;
  localparam int PUL = 4;
  localparam int PER = 8;

  logic       ref_clk;
  logic       resetn;
  logic [7:0] addr;
  logic       wr;
  logic [7:0] wdata;
  logic       rd;
  logic [7:0] rdata;
  logic [5:0] det;
  logic [2:0] ovf;
  logic       irq_a;
  logic       irq_b;
  int         err_total;
  int         samples_checked;

  adif_top #(.PULSE_CYCLES(PUL), .PERIOD_CYCLES(PER)) u_adif_top
  (
    .ref_clk_i     (ref_clk),
    .resetn_i      (resetn),
    .reg_addr_i    (addr),
    .reg_wr_i      (wr),
    .reg_wdata_i   (wdata),
    .reg_rd_i      (rd),
    .reg_rdata_o   (rdata),
    .short_left_i  (det[5]),
    .short_right_i (det[4]),
    .button_i      (det[3]),
    .headset_in_i  (det[2]),
    .power_left_i  (det[1]),
    .power_right_i (det[0]),
    .ovf_flags_i   (ovf),
    .irq_line_a_o  (irq_a),
    .irq_line_b_o  (irq_b)
  );

  adif_host_model u_host
  (
    .ref_clk_i   (ref_clk),
    .reg_addr_o  (addr),
    .reg_wr_o    (wr),
    .reg_wdata_o (wdata),
    .reg_rd_o    (rd),
    .reg_rdata_i (rdata)
  );

  initial
  begin
    ref_clk = 1'b0;
  end
  always #20 ref_clk = ~ref_clk;

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t byte %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_count(input int got, input int exp);
    samples_checked++;
    if (got != exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t count %0d exp %0d", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk_byte(d, exp);
  endtask

  // Counts rises and high cycles of both lines over n falling edges.
  task automatic win(input int n, input int ra, input int ha,
                     input int rb, input int hb);
    int   cra = 0;
    int   cha = 0;
    int   crb = 0;
    int   chb = 0;
    logic pa;
    logic pb;
    pa = irq_a;
    pb = irq_b;
    repeat (n)
    begin
      @(negedge ref_clk);
      cha += int'(irq_a === 1'b1);
      chb += int'(irq_b === 1'b1);
      cra += int'(irq_a === 1'b1 && pa === 1'b0);
      crb += int'(irq_b === 1'b1 && pb === 1'b0);
      pa = irq_a;
      pb = irq_b;
    end
    chk_count(cra, ra);
    chk_count(cha, ha);
    chk_count(crb, rb);
    chk_count(chb, hb);
  endtask

  task automatic t_map();
    for (int i = 0; i < 6; i++)
      rdc(8'h2C + 8'(i), 8'h00);
    rdc(8'h40, 8'h00);
    u_host.wr(ADDR_LINE_A, 8'hFF);
    u_host.wr(ADDR_LINE_B, 8'hA5);
    u_host.wr(ADDR_RSVD_2D, 8'h5A);
    u_host.wr(ADDR_STICKY, 8'hFF);
    rdc(ADDR_LINE_A, 8'hFF);
    rdc(ADDR_LINE_B, 8'hA5);
    rdc(ADDR_RSVD_2D, 8'h00);
    rdc(ADDR_STICKY, 8'h00);
    u_host.wr(ADDR_LINE_A, 8'h00);
    u_host.wr(ADDR_LINE_B, 8'h00);
  endtask

  // A detector held high must not set its flag again after a read.
  task automatic t_flags();
    for (int i = 0; i < 6; i++)
    begin
      det = 6'h01 << i;
      repeat (6) @(negedge ref_clk);
      rdc(ADDR_STATUS, {det, 2'h0});
      rdc(ADDR_STICKY, {det, 2'h0});
      rdc(ADDR_STICKY, 8'h00);
      det = 6'h00;
      repeat (6) @(negedge ref_clk);
      rdc(ADDR_STATUS, 8'h00);
      rdc(ADDR_STICKY, (i == 2) ? 8'h10 : 8'h00);
    end
  endtask

  task automatic t_gates();
    logic [7:0] g [5] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h04};
    logic [5:0] s [5] = '{6'h04, 6'h08, 6'h01, 6'h20, 6'h00};
    logic [7:0] d;
    for (int k = 0; k < 10; k++)
    begin
      u_host.wr(ADDR_LINE_A, (k < 5) ? g[k % 5] : 8'h00);
      u_host.wr(ADDR_LINE_B, (k < 5) ? 8'h00 : g[k % 5]);
      det = s[k % 5];
      ovf = (k == 4) ? 3'h1 : (k == 9) ? 3'h4 : 3'h0;
      if (k < 5)
        win(16, 1, PUL, 0, 0);
      else
        win(16, 0, 0, 1, PUL);
      det = 6'h00;
      ovf = 3'h0;
      repeat (16) @(negedge ref_clk);
      u_host.rd(ADDR_STICKY, d);
    end
  endtask

  task automatic t_repeat();
    logic [7:0] d;
    u_host.wr(ADDR_LINE_A, 8'h05);
    u_host.wr(ADDR_LINE_B, 8'h21);
    ovf = 3'h2;
    win(24, 3, 3 * PUL, 0, 0);
    u_host.rd(ADDR_STICKY, d);
    ovf = 3'h0;
    repeat (PER) @(negedge ref_clk);
    win(16, 0, 0, 0, 0);
    det = 6'h02;
    win(24, 0, 0, 3, 3 * PUL);
    rdc(ADDR_STICKY, 8'h08);
    det = 6'h00;
    repeat (PER) @(negedge ref_clk);
    win(16, 0, 0, 0, 0);
  endtask

  // The limit is several times the expected run, about 715 cycles.
  initial
  begin
    #(40 * 4000);
    err_total++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    end_of_test();
  end

  initial
  begin
    err_total       = 0;
    samples_checked = 0;
    resetn          = 1'b0;
    det             = 6'h00;
    ovf             = 3'h0;
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    t_map();
    t_flags();
    t_gates();
    t_repeat();
    end_of_test();
  end
endmodule
